// [twpsi_cfg.svh]
// Constants of the two-wire potentiometer slave front end.
`ifndef TWPSI_CFG_SVH
`define TWPSI_CFG_SVH

// Clock rate of sys_clk in MHz.
`define TWPSI_CLK_MHZ 100
// Typical internal nonvolatile write time in microseconds (5 ms).
`define TWPSI_NV_WRITE_US 5000
// Cycles of sys_clk for one nonvolatile write.
`define TWPSI_NV_WRITE_CYCLES (`TWPSI_NV_WRITE_US * `TWPSI_CLK_MHZ)
// Width of the nonvolatile write cycle counter.
`define TWPSI_NV_CNT_W 20

// Instruction opcodes held in the upper nibble of the instruction byte.
`define TWPSI_OP_RD_WIPER 4'h9
`define TWPSI_OP_WR_WIPER 4'ha
`define TWPSI_OP_RD_STORED 4'hb
`define TWPSI_OP_WR_STORED 4'hc
`define TWPSI_OP_STORED_TO_WIPER 4'hd
`define TWPSI_OP_WIPER_TO_STORED 4'he

// Field positions inside the instruction byte.
`define TWPSI_OPC_HI 7
`define TWPSI_OPC_LO 4
`define TWPSI_SEL_HI 3
`define TWPSI_SEL_LO 2

// Reset contents of the stored-setting registers (emulated nonvolatile cells).
`define TWPSI_STORED_RESET 6'h20

`endif

// [twpsi_pkg.sv]
// Types shared by the two-wire potentiometer slave front end.
package twpsi_pkg;

   // Protocol states of the serial slave.
   typedef enum logic [3:0] {
      TWPSI_IDLE = 4'b0000,
      TWPSI_ADDR = 4'b0001,
      TWPSI_ACK_ADDR = 4'b0010,
      TWPSI_CMD = 4'b0011,
      TWPSI_ACK_CMD = 4'b0100,
      TWPSI_WDATA = 4'b0101,
      TWPSI_ACK_DATA = 4'b0110,
      TWPSI_RDATA = 4'b0111,
      TWPSI_RACK = 4'b1000,
      TWPSI_IGNORE = 4'b1001
   } twpsi_state_t;

endpackage : twpsi_pkg

// [twpsi_slave.sv]
// Serial slave front end, wiper and stored-setting registers of a digital potentiometer.
`timescale 1ns/1ps
`include "twpsi_cfg.svh"

// Operation
// - Data changes only with clock low
// - Ignore everything until a start
// - Release after eight bits, ack ninth
// - Ack address, command and data byte
// - Upper address nibble is fixed type
// - Lower nibble must match strap pins
// - Straps allow eight devices per bus
// - Data pin open drain, low only
// - Write protect low blocks nonvolatile writes
// - Stop starts nonvolatile write, inputs off
// - No address ack while write busy
// - Six-bit wiper decodes to one tap
// - Never two taps enabled together
// - Wiper loadable directly or from stored
// - Instruction byte: opcode, select, zeros
// - Reset loads wiper from stored zero
module twpsi_slave #(
   // Device type code in the address byte; the value is arbitrary.
   parameter logic [3:0] DEV_TYPE = 4'ha,
   // Fourth compared address bit, which has no strap pin.
   parameter logic ADDR_BIT1 = 1'b0,
   // Length of one nonvolatile write in sys_clk cycles.
   parameter int NV_WRITE_CYCLES = `TWPSI_NV_WRITE_CYCLES
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Two-wire bus pins.
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Static control pins.
   input wire logic [2:0] address_strap_pins,
   input wire logic write_protect_n,
   // Potentiometer side.
   output logic [5:0] wiper_position_register,
   output logic [63:0] tap_select,
   output logic nv_busy
);

   // Raw pin vector: bit 0 clock, bit 1 data, bit 2 protect, bits 5:3 straps.
   logic [5:0] pin_raw;
   // Three synchroniser stages per pin.
   logic [5:0] sync1, sync2, sync3;
   // Filtered pin levels, updated when stages two and three agree.
   logic [5:0] pin_level;
   // Previous filtered clock and data levels.
   logic scl_prev, sda_prev;
   // Bus events.
   logic scl_rise, scl_fall, start_seen, stop_seen;
   // Protocol state.
   twpsi_pkg::twpsi_state_t state;
   // Receive shift register and bit counter.
   logic [7:0] rx_shift;
   logic [2:0] bit_cnt;
   logic byte_done;
   // Transmit shift register and latched instruction byte.
   logic [7:0] tx_shift, instr;
   // Stored-setting registers.
   logic [5:0] stored_setting_registers [4];
   // Pending nonvolatile write: armed flag, target and value.
   logic nv_armed;
   logic [1:0] nv_sel;
   logic [5:0] nv_value;
   // Nonvolatile write cycle counter.
   logic [`TWPSI_NV_CNT_W-1:0] nv_cnt;
   // Power-up recall request.
   logic recall_pending;
   // Decoded helpers.
   logic [7:0] own_address;
   logic [3:0] opcode;
   logic [1:0] sel;
   logic known_op, is_read, is_write;

   assign pin_raw = {address_strap_pins, write_protect_n, sda_in, scl_in};

   // Synchronise every pin through three stages and filter on agreement.
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
         always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
               {sync1[gi], sync2[gi], sync3[gi], pin_level[gi]} <= 4'hf;
            end else begin
               sync1[gi] <= pin_raw[gi];
               sync2[gi] <= sync1[gi];
               sync3[gi] <= sync2[gi];
               // The level changes only when the later stages agree.
               if (sync2[gi] == sync3[gi]) begin
                  pin_level[gi] <= sync3[gi];
               end
            end
         end
      end
   endgenerate

   // Remember the last filtered bus levels for edge detection.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         {sda_prev, scl_prev} <= 2'b11;
      end else begin
         {sda_prev, scl_prev} <= pin_level[1:0];
      end
   end

   // Clock edges; the device only samples the clock, never drives it.
   // slave clock only
   assign scl_rise = pin_level[0] & ~scl_prev;
   assign scl_fall = ~pin_level[0] & scl_prev;
   assign start_seen = pin_level[0] & scl_prev & sda_prev & ~pin_level[1];
   assign stop_seen = pin_level[0] & scl_prev & ~sda_prev & pin_level[1];

   // eight strap combinations
   // Three straps and the fixed fourth bit form the low nibble.
   assign own_address = {DEV_TYPE, pin_level[5], pin_level[4], ADDR_BIT1, pin_level[3]};

   assign opcode = rx_shift[`TWPSI_OPC_HI:`TWPSI_OPC_LO];
   assign sel = rx_shift[`TWPSI_SEL_HI:`TWPSI_SEL_LO];
   assign known_op = (rx_shift[1:0] == 2'b00) &&
      ((opcode == `TWPSI_OP_RD_WIPER) || (opcode == `TWPSI_OP_WR_WIPER) ||
       (opcode == `TWPSI_OP_RD_STORED) || (opcode == `TWPSI_OP_WR_STORED) ||
       (opcode == `TWPSI_OP_STORED_TO_WIPER) || (opcode == `TWPSI_OP_WIPER_TO_STORED));
   assign is_read = (instr[`TWPSI_OPC_HI:`TWPSI_OPC_LO] == `TWPSI_OP_RD_WIPER) ||
      (instr[`TWPSI_OPC_HI:`TWPSI_OPC_LO] == `TWPSI_OP_RD_STORED);
   assign is_write = (instr[`TWPSI_OPC_HI:`TWPSI_OPC_LO] == `TWPSI_OP_WR_WIPER) ||
      (instr[`TWPSI_OPC_HI:`TWPSI_OPC_LO] == `TWPSI_OP_WR_STORED);

   // Sample data on each rising clock edge in the address, command and data states; reads count their bits here too.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         {rx_shift, bit_cnt, byte_done} <= 12'h000;
      end else if (start_seen) begin
         bit_cnt <= 3'h0;
         byte_done <= 1'b0;
      end else if (scl_rise && ((state == twpsi_pkg::TWPSI_ADDR) ||
                                (state == twpsi_pkg::TWPSI_CMD) ||
                                (state == twpsi_pkg::TWPSI_WDATA) ||
                                (state == twpsi_pkg::TWPSI_RDATA))) begin
         rx_shift <= {rx_shift[6:0], pin_level[1]};
         bit_cnt <= bit_cnt + 3'h1;
         // The eighth bit completes the byte.
         byte_done <= (bit_cnt == 3'h7);
      end else if (scl_fall) begin
         byte_done <= 1'b0;
      end
   end

   // Protocol state machine, data line drive and transmit shifting.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state <= twpsi_pkg::TWPSI_IDLE;
         sda_oe <= 1'b0;
         // The pin is open drain, so its driven level stays low for good.
         sda_out <= 1'b0;
         {tx_shift, instr} <= 16'h0000;
      end else if (start_seen) begin
         state <= twpsi_pkg::TWPSI_ADDR;
         sda_oe <= 1'b0;
      end else if (stop_seen) begin
         state <= twpsi_pkg::TWPSI_IDLE;
         sda_oe <= 1'b0;
      end else if (scl_fall) begin
         case (state)
            twpsi_pkg::TWPSI_ADDR: begin
               if (byte_done) begin
                  if ((rx_shift == own_address) && !nv_busy) begin
                     state <= twpsi_pkg::TWPSI_ACK_ADDR;
                     sda_oe <= 1'b1;
                  end else begin
                     state <= twpsi_pkg::TWPSI_IGNORE;
                  end
               end
            end
            twpsi_pkg::TWPSI_ACK_ADDR: begin
               sda_oe <= 1'b0;
               state <= twpsi_pkg::TWPSI_CMD;
            end
            twpsi_pkg::TWPSI_CMD: begin
               if (byte_done) begin
                  if (known_op) begin
                     instr <= rx_shift;
                     sda_oe <= 1'b1;
                     state <= twpsi_pkg::TWPSI_ACK_CMD;
                  end else begin
                     state <= twpsi_pkg::TWPSI_IGNORE;
                  end
               end
            end
            twpsi_pkg::TWPSI_ACK_CMD: begin
               if (is_read) begin
                  // The first data bit goes out as the ack clock ends.
                  if (instr[`TWPSI_OPC_HI:`TWPSI_OPC_LO] == `TWPSI_OP_RD_WIPER) begin
                     tx_shift <= {2'b00, wiper_position_register};
                  end else begin
                     tx_shift <= {2'b00,
                        stored_setting_registers[instr[`TWPSI_SEL_HI:`TWPSI_SEL_LO]]};
                  end
                  sda_oe <= 1'b1;
                  state <= twpsi_pkg::TWPSI_RDATA;
               end else if (is_write) begin
                  sda_oe <= 1'b0;
                  state <= twpsi_pkg::TWPSI_WDATA;
               end else begin
                  sda_oe <= 1'b0;
                  state <= twpsi_pkg::TWPSI_IGNORE;
               end
            end
            twpsi_pkg::TWPSI_WDATA: begin
               if (byte_done) begin
                  sda_oe <= 1'b1;
                  state <= twpsi_pkg::TWPSI_ACK_DATA;
               end
            end
            twpsi_pkg::TWPSI_ACK_DATA: begin
               sda_oe <= 1'b0;
               state <= twpsi_pkg::TWPSI_IGNORE;
            end
            twpsi_pkg::TWPSI_RDATA: begin
               // Shift the next bit out; release after the eighth.
               tx_shift <= {tx_shift[6:0], 1'b0};
               if (byte_done) begin
                  sda_oe <= 1'b0;
                  state <= twpsi_pkg::TWPSI_RACK;
               end else begin
                  sda_oe <= ~tx_shift[6];
               end
            end
            twpsi_pkg::TWPSI_RACK: begin
               state <= twpsi_pkg::TWPSI_IGNORE;
            end
            default: begin
               // Idle and ignore wait for the next start.
               sda_oe <= 1'b0;
            end
         endcase
      end
   end

   // Wiper register: recall, direct write and copy from stored settings.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wiper_position_register <= 6'h00;
         recall_pending <= 1'b1;
      end else if (recall_pending) begin
         wiper_position_register <= stored_setting_registers[0];
         recall_pending <= 1'b0;
      end else if (scl_fall && (state == twpsi_pkg::TWPSI_WDATA) && byte_done &&
                   (instr[`TWPSI_OPC_HI:`TWPSI_OPC_LO] == `TWPSI_OP_WR_WIPER)) begin
         wiper_position_register <= rx_shift[5:0];
      end else if (scl_fall && (state == twpsi_pkg::TWPSI_CMD) && byte_done && known_op &&
                   (opcode == `TWPSI_OP_STORED_TO_WIPER)) begin
         wiper_position_register <= stored_setting_registers[sel];
      end
   end

   // Arms a nonvolatile write from a stored write or a wiper-to-stored copy.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         {nv_armed, nv_sel, nv_value} <= 9'h000;
      end else if (start_seen || stop_seen) begin
         nv_armed <= 1'b0;
      end else if (scl_fall && (state == twpsi_pkg::TWPSI_WDATA) && byte_done &&
                   (instr[`TWPSI_OPC_HI:`TWPSI_OPC_LO] == `TWPSI_OP_WR_STORED)) begin
         nv_armed <= 1'b1;
         nv_sel <= instr[`TWPSI_SEL_HI:`TWPSI_SEL_LO];
         nv_value <= rx_shift[5:0];
      end else if (scl_fall && (state == twpsi_pkg::TWPSI_CMD) && byte_done && known_op &&
                   (opcode == `TWPSI_OP_WIPER_TO_STORED)) begin
         nv_armed <= 1'b1;
         nv_sel <= sel;
         nv_value <= wiper_position_register;
      end
   end

   // Nonvolatile write cycle: starts on the stop, commits at its end.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         {nv_busy, nv_cnt} <= '0;
         for (int i = 0; i < 4; i++) begin
            stored_setting_registers[i] <= `TWPSI_STORED_RESET;
         end
      end else if (nv_busy) begin
         if (nv_cnt == '0) begin
            nv_busy <= 1'b0;
            stored_setting_registers[nv_sel] <= nv_value;
         end else begin
            nv_cnt <= nv_cnt - 1'b1;
         end
      end else if (stop_seen && nv_armed && pin_level[2]) begin
         nv_busy <= 1'b1;
         nv_cnt <= `TWPSI_NV_CNT_W'(NV_WRITE_CYCLES - 1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         tap_select <= 64'h0000000000000001;
      end else begin
         tap_select <= 64'h0000000000000001 << wiper_position_register;
      end
   end

endmodule : twpsi_slave

// [twpsi_slave_properties.sv]
// Port-level checks of the two-wire potentiometer slave.
`timescale 1ns/1ps
module twpsi_slave_properties #(
   parameter int NV_WRITE_CYCLES = 50
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Bus and control pins.
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic [2:0] address_strap_pins,
   input wire logic write_protect_n,
   // Potentiometer side.
   input wire logic [5:0] wiper_position_register,
   input wire logic [63:0] tap_select,
   input wire logic nv_busy
);
   // Busy cycles of the current nonvolatile write.
   int busy_cnt;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   // Restarts on every idle cycle so each write is timed on its own.
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !nv_busy) begin
         busy_cnt <= 0;
      end else begin
         busy_cnt <= busy_cnt + 1;
      end
   end
   a_pin_low_only: assert property (sda_oe |-> !sda_out)
      else $error("data pin driven high");
   a_tap_one_hot: assert property ($onehot(tap_select))
      else $error("tap select not one-hot");
   a_tap_follows: assert property (tap_select == (64'h1 << $past(wiper_position_register)))
      else $error("tap select does not follow the wiper");
   a_wiper_recall: assert property ($fell(sys_rst) |=> wiper_position_register == 6'h20)
      else $error("wiper not recalled from stored zero");
   a_oe_clock_low: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
      else $error("data drive changed with clock high");
   a_ack_stands: assert property ($rose(sda_oe) |-> sda_oe [*8])
      else $error("data drive dropped early");
   a_busy_quiet: assert property (nv_busy |-> !sda_oe)
      else $error("data drive while busy");
   a_busy_start: assert property ($rose(nv_busy) |-> write_protect_n && scl_in && sda_in)
      else $error("write started without stop or while protected");
   a_busy_length: assert property ($fell(nv_busy) |-> busy_cnt == NV_WRITE_CYCLES)
      else $error("nonvolatile write length wrong");
   c_ack: cover property ($rose(sda_oe));
   c_write: cover property ($rose(nv_busy));
   c_done: cover property ($fell(nv_busy));
endmodule : twpsi_slave_properties
bind twpsi_slave twpsi_slave_properties #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES))
   twpsi_slave_properties_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .scl_in(scl_in),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .address_strap_pins(address_strap_pins),
   .write_protect_n(write_protect_n), .wiper_position_register(wiper_position_register),
   .tap_select(tap_select), .nv_busy(nv_busy));

// [twpsi_master.sv]
// Behavioural two-wire bus master that makes the clock and pulls data low.
`timescale 1ns/1ps
module twpsi_master (
   // Clock.
   input wire logic sys_clk,
   // Bus lines.
   input wire logic sda_wire,
   output logic scl,
   output logic sda_pull
);
   // Phase length in sys_clk cycles; the slave needs six at least.
   localparam int HALF = 10;
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // Waits one clock phase.
   task automatic phase();
      repeat (HALF) @(posedge sys_clk);
   endtask : phase
   task automatic bit_clk(output logic seen);
      phase();
      scl <= 1'b1;
      phase();
      seen = sda_wire;
      scl <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask : bit_clk
   task automatic start();
      sda_pull <= 1'b0;
      phase();
      scl <= 1'b1;
      phase();
      sda_pull <= 1'b1;
      phase();
      scl <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask : start
   task automatic stop();
      sda_pull <= 1'b1;
      phase();
      scl <= 1'b1;
      phase();
      sda_pull <= 1'b0;
      phase();
   endtask : stop
   task automatic send(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         sda_pull <= !b[i];
         bit_clk(s);
      end
      sda_pull <= 1'b0;
      bit_clk(s);
      ack = !s;
   endtask : send
   task automatic recv(input logic nack, output logic [7:0] b);
      logic s;
      sda_pull <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
         bit_clk(b[i]);
      end
      sda_pull <= !nack;
      bit_clk(s);
   endtask : recv
endmodule : twpsi_master

// [twpsi_slave_bench.sv]
// Self-checking bench of the two-wire potentiometer slave.
`timescale 1ns/1ps
`define CHK(name, exp, got) begin \
   cmp_count++; \
   if ((got) !== (exp)) begin \
      fail_count++; \
      $display("unexpected %s: expected %h seen %h", name, exp, got); \
   end \
end
module twpsi_slave_bench;
   // Shortened write time and the device type code in use.
   localparam int NV_CYC = 600;
   localparam logic [3:0] DEV = 4'ha;
   logic sys_clk;
   logic sys_rst;
   logic scl;
   logic sda_pull;
   logic sda_wire;
   logic sda_out;
   logic sda_oe;
   logic [2:0] strap;
   logic write_protect_n;
   logic [5:0] wiper;
   logic [63:0] tap_select;
   logic nv_busy;
   int fail_count;
   int cmp_count;
   assign sda_wire = !(sda_pull || (sda_oe && !sda_out));
   twpsi_slave #(.NV_WRITE_CYCLES(NV_CYC)) twpsi_slave_i (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
      .address_strap_pins(strap), .write_protect_n(write_protect_n),
      .wiper_position_register(wiper), .tap_select(tap_select), .nv_busy(nv_busy));
   twpsi_master twpsi_master_i (.sys_clk(sys_clk), .sda_wire(sda_wire), .scl(scl),
      .sda_pull(sda_pull));
   // Address that the straps select.
   function automatic logic [7:0] addr();
      return {DEV, strap[2], strap[1], 1'b0, strap[0]};
   endfunction : addr
   // Start, one address byte, stop.
   task automatic probe(input logic [7:0] a, output logic k);
      twpsi_master_i.start();
      twpsi_master_i.send(a, k);
      twpsi_master_i.stop();
   endtask : probe
   // Whole command; every byte the master sends must be acknowledged, and a read byte gets a nack.
   task automatic op(input logic [7:0] ins, input logic [7:0] d, output logic [7:0] rd);
      logic k;
      rd = 8'h00;
      twpsi_master_i.start();
      twpsi_master_i.send(addr(), k);
      `CHK("address ack", 1'b1, k)
      twpsi_master_i.send(ins, k);
      `CHK("instruction ack", 1'b1, k)
      if (ins[7:4] == 4'ha || ins[7:4] == 4'hc) begin
         twpsi_master_i.send(d, k);
         `CHK("data ack", 1'b1, k)
      end else if (ins[7:4] == 4'h9 || ins[7:4] == 4'hb) begin
         twpsi_master_i.recv(1'b1, rd);
      end
      twpsi_master_i.stop();
   endtask : op
   // Polls at once after the stop until the address is acknowledged.
   // immediate acknowledge polling
   task automatic poll();
      logic k;
      int n;
      probe(addr(), k);
      `CHK("busy poll", 1'b0, k)
      n = 0;
      while (k !== 1'b1 && n < 20) begin
         probe(addr(), k);
         n++;
      end
      `CHK("ready poll", 1'b1, k)
      `CHK("busy end", 1'b0, nv_busy)
   endtask : poll
   task automatic t_reset();
      `CHK("wiper", 6'h20, wiper)
      `CHK("tap", 64'h1 << 32, tap_select)
      `CHK("idle drive", 1'b0, sda_oe)
      `CHK("open drain level", 1'b0, sda_out)
      $display("test reset done");
   endtask : t_reset
   // Direct wiper writes at both ends of the range, with read-back.
   task automatic t_wiper();
      logic [5:0] vals [3] = '{6'h00, 6'h3f, 6'h15};
      logic [7:0] rd;
      foreach (vals[i]) begin
         op(8'ha0, {2'b11, vals[i]}, rd);
         `CHK("wiper", vals[i], wiper)
         `CHK("tap", 64'h1 << vals[i], tap_select)
         op(8'h90, 8'h00, rd);
         `CHK("wiper read", {2'b00, vals[i]}, rd)
      end
      $display("test wiper done");
   endtask : t_wiper
   // Each strap setting; each address bit flipped once.
   task automatic t_address();
      logic k;
      for (int s = 0; s < 8; s++) begin
         strap <= 3'(s);
         repeat (8) @(posedge sys_clk);
         probe(addr(), k);
         `CHK("own address", 1'b1, k)
         probe(addr() ^ (8'h01 << s), k);
         `CHK("other address", 1'b0, k)
      end
      $display("test address done");
   endtask : t_address
   // Instruction bytes that must be refused.
   task automatic t_instr();
      logic [7:0] bad [4] = '{8'ha1, 8'h92, 8'h20, 8'hf0};
      logic k;
      foreach (bad[i]) begin
         twpsi_master_i.start();
         twpsi_master_i.send(addr(), k);
         twpsi_master_i.send(bad[i], k);
         `CHK("bad instruction ack", 1'b0, k)
         twpsi_master_i.stop();
      end
      $display("test instruction done");
   endtask : t_instr
   // Stored write, polling, read-back and copy to the wiper.
   task automatic t_nv();
      logic [7:0] rd;
      op(8'hc4, 8'h0a, rd);
      `CHK("busy", 1'b1, nv_busy)
      poll();
      op(8'hb4, 8'h00, rd);
      `CHK("stored read", 8'h0a, rd)
      op(8'hd4, 8'h00, rd);
      `CHK("wiper copy", 6'h0a, wiper)
      $display("test nonvolatile done");
   endtask : t_nv
   // Copy of the wiper into a cell, first protected, then allowed.
   task automatic t_protect();
      logic [7:0] rd;
      write_protect_n <= 1'b0;
      op(8'he8, 8'h00, rd);
      `CHK("protected busy", 1'b0, nv_busy)
      op(8'hb8, 8'h00, rd);
      `CHK("protected cell", 8'h20, rd)
      write_protect_n <= 1'b1;
      op(8'he8, 8'h00, rd);
      poll();
      op(8'hb8, 8'h00, rd);
      `CHK("copied cell", 8'h0a, rd)
      $display("test protect done");
   endtask : t_protect
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : conclude
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      sys_rst = 1'b1;
      strap = 3'h0;
      write_protect_n = 1'b1;
      fail_count = 0;
      cmp_count = 0;
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (8) @(posedge sys_clk);
      t_reset();
      t_wiper();
      t_address();
      t_instr();
      t_nv();
      t_protect();
      conclude();
   end
   // Cuts a hang short well past the expected run length.
   initial begin
      repeat (80000) @(posedge sys_clk);
      fail_count++;
      $display("watchdog expired");
      conclude();
   end
endmodule : twpsi_slave_bench
